/* tone_pkg.sv */
/*
 * Shared constants and carrier types for the tone synthesiser core.
 * Assumes a single 250 MHz core clock; no bus, all controls are ports.
 */
package tone_pkg;
    localparam int PHASE_W = 32;
    localparam int SHIFT_W = 16;
    localparam int GAIN_W = 12;
    localparam int DAC_W = 12;
    localparam int LUT_AW = 10;
    localparam int FIFO_DEPTH = 16;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int MOD_INTERVAL = 24;
    localparam int CAL_PERIODS = 469632;
    localparam logic [4:0] MOD_CNT_RESET = 5'h00;
    localparam logic [31:0] PHASE_RESET = 32'h0000_0000;
    localparam logic [11:0] GAIN_RESET = 12'hFFF;
    localparam int SINE_SEL_BIT = 16;
    localparam int CAL_BIT = 24;

    typedef struct packed {
        logic [31:0] freq_step_word;
        logic [15:0] phase_shift_word;
        logic [11:0] gain_scale_word;
    } tone_ctrl_t;

    typedef struct packed {
        logic sine_sel;
        logic cal_request;
        logic pll_path_sel;
    } tone_cfg_t;

    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_ARMED = 3'b010,
        CAL_RUN = 3'b100
    } cal_state_t;
endpackage

/* ctrl_fifo.sv */
/*
 * Small synchronous FIFO carrying control words into the core.
 * Assumes writer and reader share one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ctrl_fifo #(
    parameter int WIDTH = 60,
    parameter int DEPTH = 16
) (
    input wire logic core_clk, // core clock
    input wire logic rst_b, // async reset, active low
    input wire logic in_valid, // write request
    output logic in_ready, // room available
    input wire logic [WIDTH-1:0] in_data, // write data
    output logic out_valid, // data available
    input wire logic out_ready, // reader takes word
    output logic [WIDTH-1:0] out_data // head word, registered
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_rd;

    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    // head word registered; valid follows count of stored words
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_ready <= 1'b1;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            logic [AW:0] nxt;
            logic [AW:0] next_rd;
            nxt = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
            next_rd = rd_ptr + (AW+1)'(do_rd);
            in_ready <= (nxt != (AW+1)'(DEPTH));
            out_valid <= (nxt != '0);
            if (do_wr && (wr_ptr == next_rd)) begin
                out_data <= in_data;
            end else begin
                out_data <= mem[next_rd[AW-1:0]];
            end
        end
    end
endmodule
`default_nettype wire

/* sine_rom.sv */
/*
 * Quarter-free full sine table, one registered read port.
 * Assumes addresses arrive one per core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sine_rom (
    input wire logic core_clk, // core clock
    input wire logic [tone_pkg::LUT_AW-1:0] addr, // phase index
    output logic signed [tone_pkg::DAC_W-1:0] data // registered sample
);
    import tone_pkg::*;
    localparam int N = 1 << LUT_AW;
    logic signed [DAC_W-1:0] table_q [N];

    // table filled by elaboration-time constants, no file read
    generate
        for (genvar i = 0; i < N; i++) begin : g_tab
            localparam real ANG = 6.283185307179586 * i / N;
            assign table_q[i] = DAC_W'($rtoi(2047.0 * $sin(ANG)));
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        data <= table_q[addr];
    end
endmodule
`default_nettype wire

/* tone_synth.sv */
/*
 * Tone synthesiser core: phase accumulator, phase shift, sine/cosine
 * lookup, gain scaling, DAC sample word, DAC timing trim sequencer.
 * Assumes controls arrive on core_clk; analog parts live outside.
 */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - the sine-select bit picks a sine or a cosine waveform.
// - a 32-bit accumulator adds the frequency step word every clock.
// - step words above half range wrap modulo 2^32 with no clipping.
// - a 16-bit phase shift word is added before the table lookup.
// - the lookup result is multiplied by a 12-bit gain word over 2^12.
// - new control values are taken at most once every 24 clocks.
// - a 12-bit sample word goes to the DAC on every clock.
// - the DAC timing trim runs for 469,632 sample periods.
// - a clock-path select bit chooses multiplier loop or direct reference.
module tone_synth (
    input wire logic core_clk, // core sample clock
    input wire logic rst_b, // async reset, active low
    input wire logic ctrl_valid, // new control word offered
    output logic ctrl_ready, // fifo has room
    input wire tone_pkg::tone_ctrl_t ctrl_in, // step, shift, gain
    input wire logic sine_sel, // 1 sine, 0 cosine
    input wire logic cal_request, // calibration bit from controller
    input wire logic pll_path_sel, // 1 multiplier loop, 0 direct
    output logic [tone_pkg::DAC_W-1:0] dac_sample, // offset-binary sample
    output logic cal_busy, // trim running
    output logic cal_done, // trim finished since last request
    output logic clk_path_pll, // clock mux select
    output logic [tone_pkg::PHASE_W-1:0] phase_now // accumulator value
);
    import tone_pkg::*;

    tone_ctrl_t active;
    tone_ctrl_t fifo_word;
    logic fifo_valid;
    logic take;
    logic [4:0] mod_cnt;
    logic [PHASE_W-1:0] acc;
    logic [SHIFT_W-1:0] shifted;
    logic [LUT_AW-1:0] lut_addr;
    logic signed [DAC_W-1:0] lut_data;
    logic signed [DAC_W+GAIN_W:0] product;
    logic [19:0] cal_cnt;
    cal_state_t cal_state;
    logic cal_req_d;

    ctrl_fifo #(
        .WIDTH($bits(tone_ctrl_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .in_valid(ctrl_valid),
        .in_ready(ctrl_ready),
        .in_data(ctrl_in),
        .out_valid(fifo_valid),
        .out_ready(take),
        .out_data(fifo_word)
    );

    // update gate
    // pacing limits modulation images to multiples of clk/24
    assign take = fifo_valid && (mod_cnt == 5'(MOD_INTERVAL - 1));

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mod_cnt <= MOD_CNT_RESET;
        end else if (mod_cnt == 5'(MOD_INTERVAL - 1)) begin
            mod_cnt <= MOD_CNT_RESET;
        end else begin
            mod_cnt <= mod_cnt + 5'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            active.freq_step_word <= PHASE_RESET;
            active.phase_shift_word <= 16'h0000;
            active.gain_scale_word <= GAIN_RESET;
        end else if (take) begin
            active <= fifo_word;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc <= PHASE_RESET;
        end else begin
            acc <= acc + active.freq_step_word;
        end
    end

    // cosine is a quarter turn ahead
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            shifted <= 16'h0000;
        end else begin
            shifted <= acc[PHASE_W-1 -: SHIFT_W] + active.phase_shift_word
                + (sine_sel ? 16'h0000 : 16'h4000);
        end
    end

    assign lut_addr = shifted[SHIFT_W-1 -: LUT_AW];

    sine_rom u_rom (
        .core_clk(core_clk),
        .addr(lut_addr),
        .data(lut_data)
    );

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            product <= '0;
        end else begin
            product <= lut_data * $signed({1'b0, active.gain_scale_word});
        end
    end

    // truncate to converter width, offset binary
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dac_sample <= 12'h800;
        end else begin
            dac_sample <= product[GAIN_W +: DAC_W] ^ 12'h800;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_now <= PHASE_RESET;
        end else begin
            phase_now <= acc;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_path_pll <= 1'b0;
        end else begin
            clk_path_pll <= pll_path_sel;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cal_req_d <= 1'b0;
        end else begin
            cal_req_d <= cal_request;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cal_state <= CAL_IDLE;
            cal_cnt <= 20'h0_0000;
            cal_busy <= 1'b0;
            cal_done <= 1'b0;
        end else begin
            unique case (cal_state)
                CAL_IDLE: begin
                    if (cal_request && !cal_req_d) begin
                        cal_state <= CAL_ARMED;
                        cal_done <= 1'b0;
                    end
                end
                CAL_ARMED: begin
                    if (!cal_request) begin
                        cal_state <= CAL_RUN;
                        cal_cnt <= 20'(CAL_PERIODS - 1);
                        cal_busy <= 1'b1;
                    end
                end
                CAL_RUN: begin
                    if (cal_cnt == 20'h0_0000) begin
                        cal_state <= CAL_IDLE;
                        cal_busy <= 1'b0;
                        cal_done <= 1'b1;
                    end else begin
                        cal_cnt <= cal_cnt - 20'h0_0001;
                    end
                end
                default: begin
                    cal_state <= CAL_IDLE;
                    cal_busy <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* dac_model.sv */
/* Converter model on the far side of the tone core.
   Assumes one offset-binary word per core clock, no handshake. */
`timescale 1ns/1ps
`default_nettype none
module dac_model (
    input wire logic core_clk, // sample clock
    input wire logic rst_b, // reset, active low
    input wire logic [tone_pkg::DAC_W-1:0] sample, // word from core
    output logic [tone_pkg::DAC_W-1:0] held // word being converted
);
    import tone_pkg::*;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) held <= 12'h800;
        else held <= sample;
    end
endmodule
`default_nettype wire

/* tone_synth_assertions.sv */
/* Port checker for the tone core: clock path, phase pacing, trim sequence.
   Assumes it is bound to tone_synth and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module tone_synth_assertions (
    input wire logic core_clk, // core clock
    input wire logic rst_b, // reset, active low
    input wire logic cal_request, // trim bit
    input wire logic pll_path_sel, // path select
    input wire logic cal_busy, // trim running
    input wire logic cal_done, // trim finished
    input wire logic clk_path_pll, // mux select
    input wire logic [tone_pkg::PHASE_W-1:0] phase_now // accumulator
);
    import tone_pkg::*;
    logic [4:0] slot;
    logic [19:0] busy_cnt;
    logic armed;
    // take grid; step changes may show up to three edges past slot 23
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) slot <= 5'h00;
        else slot <= (slot == 5'h17) ? 5'h00 : slot + 5'h01;
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) busy_cnt <= 20'h0_0000;
        else busy_cnt <= cal_busy ? busy_cnt + 20'h0_0001 : 20'h0_0000;
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) armed <= 1'b0;
        else armed <= !cal_busy && (armed || $rose(cal_request));
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_arm; $rose(cal_request) && !cal_busy; endsequence
    sequence s_clear; armed && $fell(cal_request) && !cal_busy; endsequence
    a_path_high: assert property (pll_path_sel |=> clk_path_pll)
        else $error("path high not followed");
    a_path_low: assert property (!pll_path_sel |=> !clk_path_pll)
        else $error("path low not followed");
    a_step_paced: assert property (slot > 5'h04 && slot < 5'h17 |->
        phase_now - $past(phase_now) == $past(phase_now) - $past(phase_now, 2))
        else $error("phase step changed off grid");
    a_trim_start: assert property (s_clear |=> cal_busy)
        else $error("trim did not start");
    a_arm_clears: assert property (s_arm |=> !cal_done)
        else $error("done kept after request");
    a_busy_holds: assert property (cal_busy && busy_cnt < CAL_PERIODS - 1 |=> cal_busy)
        else $error("trim ended early");
    a_trim_length: assert property ($fell(cal_busy) |-> busy_cnt == CAL_PERIODS && cal_done)
        else $error("trim length wrong");
    a_done_holds: assert property (cal_done && !$rose(cal_request) |=> cal_done)
        else $error("done dropped");
endmodule
bind tone_synth tone_synth_assertions u_tone_synth_assertions (.core_clk(core_clk),
    .rst_b(rst_b), .cal_request(cal_request), .pll_path_sel(pll_path_sel),
    .cal_busy(cal_busy), .cal_done(cal_done), .clk_path_pll(clk_path_pll),
    .phase_now(phase_now));
`default_nettype wire

/* tb_tone_synth.sv */
/* Bench for the tone core: waveform, scaling, phase step, fifo, trim.
   Assumes tone_pkg, the design files and dac_model compile first. */
`timescale 1ns/1ps
`default_nettype none
module tb_tone_synth;
    import tone_pkg::*;
    logic core_clk = 1'b0, rst_b = 1'b0, ctrl_valid = 1'b0, ctrl_ready;
    logic sine_sel = 1'b0, cal_request = 1'b0, pll_path_sel = 1'b0;
    logic cal_busy, cal_done, clk_path_pll;
    logic [DAC_W-1:0] dac_sample, held;
    logic [PHASE_W-1:0] phase_now, p0;
    tone_ctrl_t ctrl_in = '0;
    logic [27:0] wt[3] = '{28'h400_0FFF, 28'h000_0800, 28'h000_0000};
    logic [11:0] ex[3] = '{12'hFFE, 12'hBFF, 12'h800};
    int err_total = 0, total_checks = 0, cycles = 0, n;
    always #2 core_clk = ~core_clk;
    tone_synth u_tone_synth (.core_clk(core_clk), .rst_b(rst_b), .ctrl_valid(ctrl_valid),
        .ctrl_ready(ctrl_ready), .ctrl_in(ctrl_in), .sine_sel(sine_sel),
        .cal_request(cal_request), .pll_path_sel(pll_path_sel), .dac_sample(dac_sample),
        .cal_busy(cal_busy), .cal_done(cal_done), .clk_path_pll(clk_path_pll),
        .phase_now(phase_now));
    dac_model u_dac_model (.core_clk(core_clk), .rst_b(rst_b), .sample(dac_sample), .held(held));
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // valid stays up so back-to-back words need no idle edge
    task automatic wr(input tone_ctrl_t w);
        ctrl_valid = 1'b1;
        ctrl_in = w;
        while (ctrl_ready !== 1'b1) cyc(1);
        cyc(1);
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 20000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        cyc(8);
        chk("rst dac", 12'h800, dac_sample);
        chk("rst ready", 1, ctrl_ready);
        rst_b = 1'b1;
        cyc(10);
        chk("cosine", 12'hFFE, held);
        sine_sel = 1'b1;
        cyc(10);
        chk("sine", 12'h800, held);
        for (int i = 0; i < 3; i++) begin
            sine_sel = (i == 0);
            wr({32'h0000_0000, wt[i]});
            ctrl_valid = 1'b0;
            cyc(60);
            chk("scaled", ex[i], held);
        end
        wr({32'hC000_0000, 28'h000_0FFF});
        ctrl_valid = 1'b0;
        cyc(60);
        p0 = phase_now;
        cyc(1);
        chk("step", 32'hC000_0000, phase_now - p0);
        wr({32'h0000_0100, 28'h000_0FFF});
        wr({32'h0000_0200, 28'h000_0FFF});
        ctrl_valid = 1'b0;
        n = 0;
        repeat (100) begin
            p0 = phase_now;
            cyc(1);
            n += ((phase_now - p0) === 32'h0000_0100);
        end
        chk("held step", 24, n);
        ctrl_valid = 1'b1;
        n = 0;
        repeat (20) begin
            n += (ctrl_ready === 1'b1);
            cyc(1);
        end
        ctrl_valid = 1'b0;
        chk("fifo takes", 1, n == 16 || n == 17);
        cyc(450);
        chk("fifo drained", 1, ctrl_ready);
        p0 = phase_now;
        cyc(1);
        chk("drained step", 32'h0000_0200, phase_now - p0);
        for (int v = 1; v >= 0; v--) begin
            pll_path_sel = v[0];
            cyc(2);
            chk("path", v, clk_path_pll);
        end
        cal_request = 1'b1;
        cyc(4);
        chk("done clear", 0, cal_done);
        cal_request = 1'b0;
        cyc(2);
        chk("trim busy", 1, cal_busy);
        cal_request = 1'b1;
        cyc(1000);
        chk("still busy", 1, cal_busy);
        conclude();
    end
endmodule
`default_nettype wire
